// ---- dv/nv_store_model.sv ----
`default_nettype none
// ==========================================
// Stored-settings memory at the far side
module nv_store_model #(
	parameter int LAG = 6
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic saveCmd,
	input wire logic failSave,
	output logic saveDone,
	output logic saveOk
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	always @(posedge clk) begin
		saveDone <= 1'b0;
		saveOk <= ~saveOk;
		if (reset) begin
			cnt <= 0;
			saveOk <= 1'b0;
		end else if (saveCmd) begin
			cnt <= LAG;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				saveDone <= 1'b1;
				saveOk <= ~failSave;
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HOLD = 8;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] ipSelectSwitch = 4'h5;
	logic [3:0] upperDigitSwitch = 4'h0;
	logic [3:0] lowerDigitSwitch = 4'h0;
	logic configButton = 1'b0;
	logic cableConnected = 1'b1;
	logic linkActive = 1'b0;
	logic commRunning = 1'b0;
	logic driveEnabled = 1'b0;
	logic dhcpBound = 1'b0;
	logic dhcpFailed = 1'b0;
	logic clkEn = 1'b1;
	logic [31:0] dhcpAddr = 32'h0A000007;
	logic [31:0] peerAddr = 32'h00000000;
	logic nvFieldbusType = 1'b0;
	logic [10:0] nvCanBitrate = 11'h000;
	logic canFrameValid = 1'b0;
	logic [10:0] measuredRateKbps = 11'h000;
	logic storeDetectedRate = 1'b0;
	logic failSave = 1'b0;
	front_panel_pkg::modbus_req_t mbReq = '0;
	front_panel_pkg::display_t display;
	logic [31:0] ipAddr, subnetMask, mbRdata;
	logic [10:0] canBitrateParam, canBootupRate, lastBoot;
	logic peerReachable, fieldbusTypeParam, nonvolatileSaveCmd, activeFieldbusType;
	logic linkLamp, runLamp, canBootupSend, autoDetectActive, mbAck, nvSaveDone, nvSaveOk;
	int badCount = 0;
	int nTests = 0;
	int saves = 0;
	int boots = 0;
	int textCyc = 0;
	int s0, b0;
	logic [10:0] rates [5] = '{11'h000, 11'h07D, 11'h0FA, 11'h1F4, 11'h3E8};

	always #50 clk = ~clk;

	front_panel_network_config #(.HOLD_CYCLES(HOLD), .BLINK_HALF_CYCLES(4)) dut (
		.clk, .reset, .clkEn, .ipSelectSwitch, .upperDigitSwitch, .lowerDigitSwitch,
		.configButton, .cableConnected, .linkActive, .commRunning, .driveEnabled, .dhcpBound,
		.dhcpAddr, .dhcpFailed, .peerAddr, .nvFieldbusType, .nvCanBitrate,
		.nvStaticAddr(front_panel_pkg::SOFT_ADDR_DEFAULT), .nvSaveDone, .nvSaveOk, .canFrameValid, .measuredRateKbps,
		.storeDetectedRate, .mbReq, .ipAddr, .subnetMask, .peerReachable, .display,
		.fieldbusTypeParam, .canBitrateParam, .nonvolatileSaveCmd, .activeFieldbusType,
		.linkLamp, .runLamp, .canBootupSend, .canBootupRate, .autoDetectActive, .mbAck, .mbRdata
	);

	nv_store_model #(.LAG(6)) nv (
		.clk, .reset, .saveCmd(nonvolatileSaveCmd), .failSave, .saveDone(nvSaveDone),
		.saveOk(nvSaveOk)
	);

	// ==========================================
	// Event counters
	always @(posedge clk) begin
		if (nonvolatileSaveCmd === 1'b1)
			saves <= saves + 1;
		if (canBootupSend === 1'b1)
			boots <= boots + 1;
		if (canBootupSend === 1'b1)
			lastBoot <= canBootupRate;
		if (display.kind === front_panel_pkg::DISP_TEXT)
			textCyc <= textCyc + 1;
	end

	// ==========================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			badCount++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask

	task automatic restart(input logic [3:0] ip, input logic t, input logic [10:0] r);
		@(posedge clk);
		reset <= 1'b1;
		ipSelectSwitch <= ip;
		nvFieldbusType <= t;
		nvCanBitrate <= r;
		step(8);
		@(posedge clk);
		reset <= 1'b0;
		step(2);
	endtask

	task automatic press(input logic [3:0] u, input logic [3:0] l, input int n);
		@(posedge clk);
		upperDigitSwitch <= u;
		lowerDigitSwitch <= l;
		configButton <= 1'b1;
		step(n);
		@(posedge clk);
		configButton <= 1'b0;
		step(1);
	endtask

	task automatic waitKind(input logic [1:0] k);
		for (int i = 0; i < 200 && display.kind !== k; i++)
			step(1);
		chk("display kind", 32'(display.kind), 32'(k));
	endtask

	task automatic mb(input logic w, input logic [1:0] idx, input logic [31:0] d);
		@(posedge clk);
		mbReq <= '{1'b1, w, idx, d};
		@(posedge clk);
		mbReq.valid <= 1'b0;
		#10;
		chk("mbAck", 32'(mbAck), 32'h1); // answer one cycle
	endtask

	// ==========================================
	// Scenarios
	task automatic testIp;
		@(posedge clk);
		cableConnected <= 1'b0;
		dhcpBound <= 1'b1;
		restart(4'h0, 1'b0, 11'h07D);
		chk("ipAddr dhcp", ipAddr, dhcpAddr);
		chk("blank", 32'(display.kind), 32'h0); // no cable
		@(posedge clk);
		dhcpBound <= 1'b0;
		dhcpFailed <= 1'b1;
		step(2);
		chk("link-local", 32'(ipAddr[31:16]), 32'hA9FE);
		@(posedge clk);
		cableConnected <= 1'b1;
		restart(4'h1, 1'b0, 11'h07D);
		chk("ipAddr soft", ipAddr, 32'hC0A80165);
		restart(4'h5, 1'b0, 11'h07D);
		chk("ipAddr switch", ipAddr, 32'hC0A80069);
		chk("mask", subnetMask, 32'hFFFFFF00);
		chk("shows addr", 32'(display.kind), 32'h1);
		@(posedge clk);
		ipSelectSwitch <= 4'h2;
		step(4);
		chk("ipAddr held", ipAddr, 32'hC0A80069);
		$display("done: addressing");
	endtask

	task automatic testNet;
		@(posedge clk);
		peerAddr <= 32'hC0A80001;
		linkActive <= 1'b1;
		step(2);
		chk("peer ok", 32'(peerReachable), 32'h1);
		chk("link lamp", 32'({linkLamp, runLamp}), 32'h2);
		@(posedge clk);
		peerAddr <= 32'hC0A80069;
		linkActive <= 1'b0;
		commRunning <= 1'b1;
		step(2);
		chk("peer same", 32'(peerReachable), 32'h0);
		chk("run lamp", 32'({linkLamp, runLamp}), 32'h1);
		@(posedge clk);
		peerAddr <= 32'hC0A80169;
		step(2);
		chk("peer other net", 32'(peerReachable), 32'h0);
		@(posedge clk);
		clkEn <= 1'b0;
		linkActive <= 1'b1;
		step(3);
		chk("frozen lamp", 32'(linkLamp), 32'h0);
		@(posedge clk);
		clkEn <= 1'b1;
		step(2);
		chk("thawed lamp", 32'(linkLamp), 32'h1);
		$display("done: network");
	endtask

	task automatic testModbus;
		mb(1'b1, front_panel_pkg::PARAM_RATE, 32'd250);
		chk("rate write", 32'(canBitrateParam), 32'h0FA);
		mb(1'b1, front_panel_pkg::PARAM_RATE, 32'd300);
		chk("bad rate", 32'(canBitrateParam), 32'h0FA);
		mb(1'b0, front_panel_pkg::PARAM_RATE, 32'h0);
		chk("rate read", mbRdata, 32'h0FA);
		mb(1'b1, front_panel_pkg::PARAM_ACTIVE_ADDR, 32'h0);
		mb(1'b0, front_panel_pkg::PARAM_ACTIVE_ADDR, 32'h0);
		chk("addr read", mbRdata, 32'hC0A80069);
		$display("done: modbus");
	endtask

	task automatic testShort;
		s0 = saves;
		press(4'h8, 4'h9, HOLD - 2);
		step(HOLD + 4);
		chk("short saves", 32'(saves - s0), 32'h0);
		chk("short fbus", 32'(fieldbusTypeParam), 32'h0);
		$display("done: short press");
	endtask

	task automatic testRates;
		for (int l = 0; l < 5; l++) begin
			s0 = saves;
			press(4'h9, 4'(l), HOLD + 1);
			chk("value kind", 32'(display.kind), 32'h3);
			chk("value code", 32'(display.code), 32'({4'h9, 4'(l)}));
			chk("rate param", 32'(canBitrateParam), 32'(rates[l]));
			step(2);
			chk("blink off", 32'(display.lit), 32'h0);
			waitKind(front_panel_pkg::DISP_ADDR);
			chk("rate saves", 32'(saves - s0), 32'h1);
		end
		$display("done: rate select");
	endtask

	task automatic testErrors;
		logic [3:0] low [3] = '{4'h2, 4'h1, 4'h7};
		logic [7:0] code [3] = '{8'hE1, 8'hE2, 8'hE3};
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			driveEnabled <= (i == 0);
			failSave <= (i == 1);
			s0 = textCyc;
			press(4'h9, low[i], HOLD + 1);
			waitKind(front_panel_pkg::DISP_TEXT);
			chk("err code", 32'(display.code), 32'(code[i]));
			waitKind(front_panel_pkg::DISP_ADDR);
			chk("flash span", 32'((textCyc - s0) / 4), 32'(2 * front_panel_pkg::ERR_FLASH_COUNT));
		end
		@(posedge clk);
		driveEnabled <= 1'b0;
		failSave <= 1'b0;
		$display("done: errors");
	endtask

	task automatic testFbus;
		s0 = saves;
		press(4'h8, 4'h9, HOLD + 1);
		chk("can text", 32'(display.code), 32'hC0);
		chk("fbus param", 32'(fieldbusTypeParam), 32'h1);
		waitKind(front_panel_pkg::DISP_ADDR);
		chk("fbus saves", 32'(saves - s0), 32'h1);
		chk("fbus active", 32'(activeFieldbusType), 32'h0);
		restart(4'h5, 1'b0, 11'h07D);
		@(posedge clk);
		failSave <= 1'b1;
		press(4'h8, 4'h9, HOLD + 1);
		step(20);
		chk("fail text", 32'(display.code), 32'hEF);
		chk("fail param", 32'(fieldbusTypeParam), 32'h0);
		@(posedge clk);
		failSave <= 1'b0;
		$display("done: fieldbus type");
	endtask

	task automatic testBoot;
		b0 = boots;
		restart(4'h5, 1'b1, 11'h0FA);
		step(2);
		chk("fixed boots", 32'(boots - b0), 32'h1);
		chk("fixed rate", 32'(lastBoot), 32'h0FA);
		chk("active after cycle", 32'(activeFieldbusType), 32'h1);
		@(posedge clk);
		driveEnabled <= 1'b1;
		restart(4'h5, 1'b1, 11'h000);
		b0 = boots;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			canFrameValid <= 1'b1;
			measuredRateKbps <= 11'h1F4;
			@(posedge clk);
			canFrameValid <= 1'b0;
			driveEnabled <= 1'b0;
			step(3);
			chk("auto boots", 32'(boots - b0), 32'(i));
			chk("auto listen", 32'(autoDetectActive), 32'(1 - i));
		end
		chk("auto rate", 32'(lastBoot), 32'h1F4);
		s0 = saves;
		@(posedge clk);
		storeDetectedRate <= 1'b1;
		@(posedge clk);
		storeDetectedRate <= 1'b0;
		step(3);
		chk("stored rate", 32'(canBitrateParam), 32'h1F4);
		chk("store save", 32'(saves - s0), 32'h1);
		$display("done: boot-up");
	endtask

	// ==========================================
	// Verdict
	task automatic finishTest;
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		finishTest();
	end

	initial begin
		testIp();
		testNet();
		testModbus();
		testShort();
		testRates();
		testErrors();
		testFbus();
		testBoot();
		finishTest();
	end
endmodule
`default_nettype wire

// ---- logic/front_panel_network_config.sv ----
`default_nettype none
// Behaviour
// (R1) Position 0: DHCP, else 169.254 link-local
// (R2) Position 1: software address, default 192.168.1.101
// (R3) Positions 2-9: address 192.168.0.10n
// (R4) Show address at power-on, cable connect only
// (R5) Switch changes apply after power cycle
// (R6) Mask 255.255.255.0; peer shares three octets
// (R7) Link and run lamps follow status
// (R8) Modbus client reads and writes parameters
// (R9) 89 plus 3 s hold: CAN, save
// (R10) Show CAN indication, then restore display
// (R11) Failed type change shows failure indication
// (R12) Bit-rate codes 0 auto, 125-1000 fixed
// (R13) Values 90-94 select auto through 1000
// (R14) Fixed rate: boot-up at stored rate
// (R15) Auto: wait frame, boot-up at measured rate
// (R16) Detected rate storable; else detect each start
// (R17) Auto detection only while drive disabled
// (R18) Held rate value: blink, write, save all
// (R19) Failures flash code five times: 1,2,3
// (R20) Sample switches at qualified hold; ignore short
module front_panel_network_config #(
	parameter int HOLD_CYCLES = front_panel_pkg::HOLD_CYCLES,
	parameter int BLINK_HALF_CYCLES = front_panel_pkg::BLINK_HALF_CYCLES,
	parameter logic [15:0] LINK_LOCAL_HOST = 16'h0101
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [3:0] ipSelectSwitch,
	input wire logic [3:0] upperDigitSwitch,
	input wire logic [3:0] lowerDigitSwitch,
	input wire logic configButton,
	input wire logic cableConnected,
	input wire logic linkActive,
	input wire logic commRunning,
	input wire logic driveEnabled,
	input wire logic dhcpBound,
	input wire logic [31:0] dhcpAddr,
	input wire logic dhcpFailed,
	input wire logic [31:0] peerAddr,
	input wire logic nvFieldbusType,
	input wire logic [10:0] nvCanBitrate,
	input wire logic [31:0] nvStaticAddr,
	input wire logic nvSaveDone,
	input wire logic nvSaveOk,
	input wire logic canFrameValid,
	input wire logic [10:0] measuredRateKbps,
	input wire logic storeDetectedRate,
	input wire front_panel_pkg::modbus_req_t mbReq,
	output logic [31:0] ipAddr,
	output logic [31:0] subnetMask,
	output logic peerReachable,
	output front_panel_pkg::display_t display,
	output logic fieldbusTypeParam,
	output logic [10:0] canBitrateParam,
	output logic nonvolatileSaveCmd,
	output logic activeFieldbusType,
	output logic linkLamp,
	output logic runLamp,
	output logic canBootupSend,
	output logic [10:0] canBootupRate,
	output logic autoDetectActive,
	output logic mbAck,
	output logic [31:0] mbRdata
);
	localparam logic [31:0] BLINK_LAST = 32'(BLINK_HALF_CYCLES - 1);

	typedef enum logic [5:0] {
		ST_START = 6'b000001,
		ST_IDLE = 6'b000010,
		ST_CAN_CHANGE = 6'b000100,
		ST_RATE_SAVE = 6'b001000,
		ST_ERR_FLASH = 6'b010000,
		ST_FAIL = 6'b100000
	} state_e_t;

	typedef struct packed {
		state_e_t st;
		logic [3:0] ipSel;
		logic [31:0] ipAddr;
		logic [31:0] mask;
		logic peerOk;
		logic [31:0] softAddr;
		logic fbParam;
		logic activeFb;
		logic [10:0] rateParam;
		logic [10:0] activeRate;
		front_panel_pkg::display_t disp;
		front_panel_pkg::display_t baseDisp;
		logic cablePrev;
		logic nvSave;
		logic [31:0] blinkCnt;
		logic [3:0] flashCnt;
		logic linkLamp;
		logic runLamp;
		logic bootDone;
		logic bootSend;
		logic [10:0] bootRate;
		logic autoDetect;
		logic mbAck;
		logic [31:0] mbRdata;
	} state_t;

	state_t q;
	state_t d;
	logic holdQualified;
	logic [7:0] sel;

	assign sel = {upperDigitSwitch, lowerDigitSwitch};

	hold_timer #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) holdTimer (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.button(configButton),
		.qualified(holdQualified)
	);

	// ==========================================================
	// Next state
	always_comb begin
		d = q;
		d.nvSave = 1'b0;
		d.bootSend = 1'b0;
		d.mbAck = 1'b0;
		// (R7) lamps track link and run status
		d.linkLamp = linkActive;
		d.runLamp = commRunning;
		d.cablePrev = cableConnected;
		// (R6) peer subnet check
		d.peerOk = (peerAddr[31:8] == q.ipAddr[31:8]) && (peerAddr[7:0] != q.ipAddr[7:0]);
		// (R1) DHCP then link-local
		case (q.ipSel)
			front_panel_pkg::IP_POS_DHCP: begin
				if (dhcpBound) begin
					d.ipAddr = dhcpAddr;
				end else if (dhcpFailed) begin
					d.ipAddr = {front_panel_pkg::LINK_LOCAL_PREFIX, LINK_LOCAL_HOST};
				end
			end
			// (R2) software static address
			front_panel_pkg::IP_POS_SOFT: d.ipAddr = q.softAddr;
			// (R3) switch static address
			default: d.ipAddr = front_panel_pkg::SWITCH_ADDR_BASE + {28'h0, q.ipSel};
		endcase
		// (R4) address shown on connect, none without cable
		if (!cableConnected) begin
			d.baseDisp = '{kind: front_panel_pkg::DISP_BLANK, code: 8'h00, lit: 1'b0};
		end else if (!q.cablePrev) begin
			d.baseDisp = '{kind: front_panel_pkg::DISP_ADDR, code: 8'h00, lit: 1'b1};
		end
		// (R8) Modbus parameter access
		if (mbReq.valid) begin
			d.mbAck = 1'b1;
			d.mbRdata = 32'h0;
			case (mbReq.index)
				front_panel_pkg::PARAM_FBUS: begin
					d.mbRdata = {31'h0, q.fbParam};
					if (mbReq.write) begin
						d.fbParam = mbReq.data[0];
					end
				end
				front_panel_pkg::PARAM_RATE: begin
					d.mbRdata = {21'h0, q.rateParam};
					// (R12) only listed codes accepted
					if (mbReq.write && front_panel_pkg::rate_valid(mbReq.data[10:0])) begin
						d.rateParam = mbReq.data[10:0];
					end
				end
				front_panel_pkg::PARAM_ADDR: begin
					d.mbRdata = q.softAddr;
					if (mbReq.write) begin
						d.softAddr = mbReq.data;
					end
				end
				default: d.mbRdata = q.ipAddr;
			endcase
		end
		// Blink timebase
		if (q.st == ST_RATE_SAVE || q.st == ST_ERR_FLASH) begin
			if (q.blinkCnt == BLINK_LAST) begin
				d.blinkCnt = 32'h0;
				d.disp.lit = !q.disp.lit;
			end else begin
				d.blinkCnt = q.blinkCnt + 32'h1;
			end
		end
		case (q.st)
			ST_START: begin
				// (R5) catch switch and stored settings once
				d.ipSel = ipSelectSwitch;
				d.mask = front_panel_pkg::SUBNET_MASK;
				d.fbParam = nvFieldbusType;
				d.activeFb = nvFieldbusType;
				d.rateParam = nvCanBitrate;
				d.activeRate = nvCanBitrate;
				d.softAddr = nvStaticAddr;
				d.ipAddr = 32'h0;
				d.baseDisp = '{kind: cableConnected ? front_panel_pkg::DISP_ADDR : front_panel_pkg::DISP_BLANK,
					code: 8'h00, lit: cableConnected};
				d.st = ST_IDLE;
			end
			ST_IDLE: begin
				d.disp = d.baseDisp;
				d.blinkCnt = 32'h0;
				// (R20) switches sampled at qualified hold
				if (holdQualified) begin
					if (sel == front_panel_pkg::SEL_FBUS_CHANGE) begin
						// (R9) switch to CAN and save
						d.fbParam = front_panel_pkg::FBUS_CAN;
						d.nvSave = 1'b1;
						d.disp = '{kind: front_panel_pkg::DISP_TEXT, code: front_panel_pkg::TXT_CAN_CHANGE, lit: 1'b1};
						d.st = ST_CAN_CHANGE;
					end else if (upperDigitSwitch == front_panel_pkg::SEL_RATE_UPPER) begin
						d.flashCnt = 4'h0;
						d.disp.lit = 1'b1;
						d.disp.kind = front_panel_pkg::DISP_TEXT;
						if (lowerDigitSwitch > front_panel_pkg::SEL_RATE_LOWER_MAX) begin
							// (R19) invalid selection
							d.disp.code = front_panel_pkg::TXT_ERR_SELECT;
							d.st = ST_ERR_FLASH;
						end else if (driveEnabled) begin
							// (R19) drive enabled
							d.disp.code = front_panel_pkg::TXT_ERR_ENABLED;
							d.st = ST_ERR_FLASH;
						end else begin
							// (R13) digit selects rate code
							d.rateParam = front_panel_pkg::rate_of(lowerDigitSwitch);
							d.nvSave = 1'b1;
							d.disp = '{kind: front_panel_pkg::DISP_VALUE, code: sel, lit: 1'b1};
							d.st = ST_RATE_SAVE;
						end
					end
				end
			end
			ST_CAN_CHANGE: begin
				// (R10) indication held until save ends
				if (nvSaveDone) begin
					if (nvSaveOk) begin
						d.st = ST_IDLE;
					end else begin
						// (R11) failure indication
						d.fbParam = q.activeFb;
						d.disp = '{kind: front_panel_pkg::DISP_TEXT, code: front_panel_pkg::TXT_FAILURE, lit: 1'b1};
						d.st = ST_FAIL;
					end
				end
			end
			ST_RATE_SAVE: begin
				// (R18) blink value while saving
				if (nvSaveDone) begin
					if (nvSaveOk) begin
						d.st = ST_IDLE;
					end else begin
						d.blinkCnt = 32'h0;
						d.flashCnt = 4'h0;
						d.disp = '{kind: front_panel_pkg::DISP_TEXT, code: front_panel_pkg::TXT_ERR_STORE, lit: 1'b1};
						d.st = ST_ERR_FLASH;
					end
				end
			end
			ST_ERR_FLASH: begin
				// (R19) five flashes then back
				if (q.blinkCnt == BLINK_LAST) begin
					d.flashCnt = q.flashCnt + 4'h1;
					if (q.flashCnt == front_panel_pkg::FLASH_HALVES - 4'h1) begin
						d.st = ST_IDLE;
					end
				end
			end
			ST_FAIL: d.st = ST_FAIL;
			default: d.st = ST_IDLE;
		endcase
		// (R14) (R15) boot-up message after start
		if (q.st != ST_START && !q.bootDone && q.activeFb == front_panel_pkg::FBUS_CAN) begin
			if (q.activeRate != front_panel_pkg::RATE_AUTO) begin
				d.bootSend = 1'b1;
				d.bootRate = q.activeRate;
				d.bootDone = 1'b1;
			end else begin
				// (R17) detection only when disabled
				d.autoDetect = !driveEnabled;
				if (canFrameValid && !driveEnabled) begin
					d.bootSend = 1'b1;
					d.bootRate = measuredRateKbps;
					d.bootDone = 1'b1;
					d.autoDetect = 1'b0;
				end
			end
		end
		// (R16) store detected rate on request
		if (storeDetectedRate && q.bootDone && q.activeRate == front_panel_pkg::RATE_AUTO) begin
			d.rateParam = q.bootRate;
			d.nvSave = 1'b1;
		end
		if (reset) begin
			d = '0;
			d.st = ST_START;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || clkEn) begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	assign ipAddr = q.ipAddr;
	assign subnetMask = q.mask;
	assign peerReachable = q.peerOk;
	assign display = q.disp;
	assign fieldbusTypeParam = q.fbParam;
	assign canBitrateParam = q.rateParam;
	assign nonvolatileSaveCmd = q.nvSave;
	assign activeFieldbusType = q.activeFb;
	assign linkLamp = q.linkLamp;
	assign runLamp = q.runLamp;
	assign canBootupSend = q.bootSend;
	assign canBootupRate = q.bootRate;
	assign autoDetectActive = q.autoDetect;
	assign mbAck = q.mbAck;
	assign mbRdata = q.mbRdata;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_held(logic [7:0] v);
		q.st == ST_IDLE && holdQualified && clkEn && sel == v;
	endsequence

	a_switch_frozen: assert property (q.st != ST_START |=> $stable(q.ipSel)) // (R5)
		else $error("ip select changed while running");
	a_mask_fixed: assert property (q.st == ST_IDLE |-> subnetMask == 32'hFFFFFF00) // (R6)
		else $error("subnet mask wrong");
	a_lamps_follow: assert property (clkEn |=> linkLamp == $past(linkActive) && runLamp == $past(commRunning)) // (R7)
		else $error("lamp does not follow status");
	a_link_local: assert property (q.st == ST_IDLE && clkEn && q.ipSel == 4'h0 && dhcpFailed && !dhcpBound // (R1)
		|=> ipAddr[31:16] == 16'hA9FE)
		else $error("no link-local fallback");
	a_switch_addr: assert property (q.st == ST_IDLE && clkEn && q.ipSel == 4'h5 |=> ipAddr == 32'hC0A80069) // (R3)
		else $error("switch address wrong");
	a_can_change: assert property (s_held(8'h89) |=> q.st == ST_CAN_CHANGE && nonvolatileSaveCmd // (R9)
		&& fieldbusTypeParam && display.code == front_panel_pkg::TXT_CAN_CHANGE)
		else $error("type change not started");
	a_rate_250: assert property (s_held(8'h92) and !driveEnabled |=> canBitrateParam == 11'h0FA // (R13)
		&& q.st == ST_RATE_SAVE ##1 display.kind == front_panel_pkg::DISP_VALUE)
		else $error("rate selection wrong");
	a_bad_select: assert property (s_held(8'h97) |=> q.st == ST_ERR_FLASH && display.code == 8'hE3) // (R19)
		else $error("invalid selection not flagged");
	a_short_press: assert property (q.st == ST_IDLE && !holdQualified && clkEn |=> q.st == ST_IDLE) // (R20)
		else $error("action without qualified hold");
	a_auto_boot: assert property (q.activeRate == 11'h000 && q.activeFb && !q.bootDone && q.st != ST_START // (R15)
		&& canFrameValid && !driveEnabled && clkEn |=> canBootupSend && canBootupRate == $past(measuredRateKbps))
		else $error("auto boot-up missing");
	a_auto_disabled: assert property (autoDetectActive |-> !$past(driveEnabled)) // (R17)
		else $error("detection while enabled");
endmodule
`default_nettype wire

// ---- logic/front_panel_pkg.sv ----
`default_nettype none
package front_panel_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int HOLD_TIME_MS = 3000;
	localparam int HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);
	localparam int ERR_FLASH_COUNT = 5;
	localparam logic [3:0] FLASH_HALVES = 4'(2 * ERR_FLASH_COUNT);

	// ==========================================================
	// Addressing
	localparam logic [3:0] IP_POS_DHCP = 4'h0;
	localparam logic [3:0] IP_POS_SOFT = 4'h1;
	localparam logic [31:0] SOFT_ADDR_DEFAULT = 32'hC0A80165;
	localparam logic [31:0] SWITCH_ADDR_BASE = 32'hC0A80064;
	localparam logic [15:0] LINK_LOCAL_PREFIX = 16'hA9FE;
	localparam logic [31:0] SUBNET_MASK = 32'hFFFFFF00;

	// ==========================================================
	// Switch selections (two BCD digits)
	localparam logic [7:0] SEL_FBUS_CHANGE = 8'h89;
	localparam logic [3:0] SEL_RATE_UPPER = 4'h9;
	localparam logic [3:0] SEL_RATE_LOWER_MAX = 4'h4;

	// ==========================================================
	// CAN bit-rate parameter codes, kbit/s
	localparam logic [10:0] RATE_AUTO = 11'h000;
	localparam logic [10:0] RATE_125 = 11'h07D;
	localparam logic [10:0] RATE_250 = 11'h0FA;
	localparam logic [10:0] RATE_500 = 11'h1F4;
	localparam logic [10:0] RATE_1000 = 11'h3E8;

	localparam logic FBUS_OTHER = 1'h0;
	localparam logic FBUS_CAN = 1'h1;

	// ==========================================================
	// Parameter indexes on the Modbus side
	localparam logic [1:0] PARAM_FBUS = 2'h0;
	localparam logic [1:0] PARAM_RATE = 2'h1;
	localparam logic [1:0] PARAM_ADDR = 2'h2;
	localparam logic [1:0] PARAM_ACTIVE_ADDR = 2'h3;

	// ==========================================================
	// Display
	localparam logic [1:0] DISP_BLANK = 2'h0;
	localparam logic [1:0] DISP_ADDR = 2'h1;
	localparam logic [1:0] DISP_TEXT = 2'h2;
	localparam logic [1:0] DISP_VALUE = 2'h3;
	localparam logic [7:0] TXT_CAN_CHANGE = 8'hC0;
	localparam logic [7:0] TXT_FAILURE = 8'hEF;
	localparam logic [7:0] TXT_ERR_ENABLED = 8'hE1;
	localparam logic [7:0] TXT_ERR_STORE = 8'hE2;
	localparam logic [7:0] TXT_ERR_SELECT = 8'hE3;

	typedef struct packed {
		logic [1:0] kind;
		logic [7:0] code;
		logic lit;
	} display_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] index;
		logic [31:0] data;
	} modbus_req_t;

	function automatic logic [10:0] rate_of(input logic [3:0] lower);
		case (lower)
			4'h0: rate_of = RATE_AUTO;
			4'h1: rate_of = RATE_125;
			4'h2: rate_of = RATE_250;
			4'h3: rate_of = RATE_500;
			default: rate_of = RATE_1000;
		endcase
	endfunction

	function automatic logic rate_valid(input logic [10:0] r);
		rate_valid = (r == RATE_AUTO) || (r == RATE_125) || (r == RATE_250) || (r == RATE_500) ||
			(r == RATE_1000);
	endfunction

endpackage
`default_nettype wire

// ---- logic/hold_timer.sv ----
`default_nettype none
module hold_timer #(
	parameter int HOLD_CYCLES = front_panel_pkg::HOLD_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic button,
	output logic qualified
);
	localparam int W = $clog2(HOLD_CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(HOLD_CYCLES - 1);

	typedef struct packed {
		logic [W-1:0] count;
		logic armed;
		logic pulse;
	} timer_t;

	timer_t q;
	timer_t d;

	always_comb begin
		d = q;
		d.pulse = 1'b0;
		if (reset) begin
			d = '0;
			d.armed = 1'b1;
		end else if (!button) begin
			// Release before the hold time ends drops the press
			d.count = '0;
			d.armed = 1'b1;
		end else if (q.armed) begin
			if (q.count == LAST) begin
				d.pulse = 1'b1;
				d.armed = 1'b0;
			end else begin
				d.count = q.count + W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset || clkEn) begin
			q <= d;
		end
	end

	assign qualified = q.pulse;
endmodule
`default_nettype wire
